// ### src/pcc_pkg.sv
package pcc_pkg;
	// clock and timebase
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int MS_PERIOD_PS   = 1000000000;
	localparam int MS_CYCLES      = MS_PERIOD_PS / CLK_PERIOD_PS;
	localparam int MS_PER_SECOND  = 1000;

	// supply loss that forces a dark cycle
	localparam int OUTAGE_MS      = 1500;
	// hand lit this long without a break is taken as the steady hand
	localparam int STEADY_MS      = 1200;
	// walk and hand both dark this long is taken as a dark head
	localparam int DARK_MS        = 1200;

	localparam int MS_W           = 11;
	localparam int DIV_W          = 18;
	localparam int CNT_W          = 7;
	localparam logic [CNT_W-1:0] MAX_COUNT = 7'h63;
	localparam logic [CNT_W-1:0] COUNT_RST = 7'h00;

	typedef enum logic [3:0]
	{
		ST_LEARN_WAIT = 4'b0001,
		ST_LEARN_MEAS = 4'b0010,
		ST_IDLE       = 4'b0100,
		ST_COUNT      = 4'b1000
	} pcc_state_type;
endpackage

// ### src/pcc_digit.sv
`timescale 1ns/1ps
module pcc_digit
	import pcc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       blank,
	input  wire logic [3:0] value,
	output logic      [6:0] seg
);
	import pcc_pkg::*;

	logic [6:0] next_seg;

	// segment order {g,f,e,d,c,b,a}, high lights the segment
	always_comb
	begin
		next_seg = 7'h00;
		if (!blank)
		begin
			case (value)
				4'h0: next_seg = 7'h3f;
				4'h1: next_seg = 7'h06;
				4'h2: next_seg = 7'h5b;
				4'h3: next_seg = 7'h4f;
				4'h4: next_seg = 7'h66;
				4'h5: next_seg = 7'h6d;
				4'h6: next_seg = 7'h7d;
				4'h7: next_seg = 7'h07;
				4'h8: next_seg = 7'h7f;
				4'h9: next_seg = 7'h6f;
				default: next_seg = 7'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			seg <= 7'h00;
		else
			seg <= next_seg;
	end
endmodule // pcc_digit

// ### src/pcc_countdown.sv
// Operation
// - single mode: count on flash, blank on steady
// - dark learning cycle after power-on
// - timing change: blank, relearn over one cycle
// - back-to-back cycles without steady hand allowed
// - walk cut short: count from flash start
// - preempt during flash: keep counting on
// - next cycle uses the learned value
// - early steady or dark head: stop, blank
// - outage over 1.5 s: one dark cycle
// - two seven-segment digits, two emitter rows
// - no user controls alter the cycle
// - no light without power, never dimmed
`timescale 1ns/1ps
module pcc_countdown
	import pcc_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       walk_drive,
	input  wire logic       hand_drive,
	input  wire logic       supply_ok,
	output logic      [6:0] seg_tens,
	output logic      [6:0] seg_ones
);
	import pcc_pkg::*;

	logic             walk_q1, walk_s, hand_q1, hand_s, pwr_q1, pwr_s;
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic             ms_tick;
	logic [MS_W-1:0]  hi_ms, next_hi_ms, lo_ms, next_lo_ms;
	logic [MS_W-1:0]  out_ms, next_out_ms, sec_ms, next_sec_ms;
	logic             long_out, next_long_out;
	logic             flash_prev, steady, dark, flash, flash_start, flash_end;
	logic             sec_tick;
	pcc_state_type    state, next_state;
	logic [CNT_W-1:0] learned, next_learned, remain, next_remain;
	logic [CNT_W-1:0] meas, next_meas, short_prev, next_short_prev;
	logic             show;
	logic [3:0]       tens_val, ones_val;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			walk_q1 <= 1'b0;
			walk_s  <= 1'b0;
			hand_q1 <= 1'b0;
			hand_s  <= 1'b0;
			pwr_q1  <= 1'b0;
			pwr_s   <= 1'b0;
		end
		else
		begin
			walk_q1 <= walk_drive;
			walk_s  <= walk_q1;
			hand_q1 <= hand_drive;
			hand_s  <= hand_q1;
			pwr_q1  <= supply_ok;
			pwr_s   <= pwr_q1;
		end
	end

	// millisecond timebase and saturating interval timers
	always_comb
	begin
		ms_tick      = (div_cnt == DIV_W'(MS_DIV - 1));
		next_div_cnt = ms_tick ? '0 : div_cnt + 1'b1;
		next_hi_ms   = hi_ms;
		next_lo_ms   = lo_ms;
		next_out_ms  = out_ms;
		next_sec_ms  = sec_ms;
		next_long_out = long_out;
		if (!hand_s)
			next_hi_ms = '0;
		else if (ms_tick && hi_ms != MS_W'(STEADY_MS))
			next_hi_ms = hi_ms + 1'b1;
		if (hand_s || walk_s)
			next_lo_ms = '0;
		else if (ms_tick && lo_ms != MS_W'(DARK_MS))
			next_lo_ms = lo_ms + 1'b1;
		if (pwr_s)
		begin
			next_out_ms   = '0;
			next_long_out = 1'b0;
		end
		else if (ms_tick && out_ms != MS_W'(OUTAGE_MS))
			next_out_ms = out_ms + 1'b1;
		else if (out_ms == MS_W'(OUTAGE_MS))
			next_long_out = 1'b1;
		// second boundary realigned to each flash start
		if (flash_start || sec_tick)
			next_sec_ms = '0;
		else if (ms_tick)
			next_sec_ms = sec_ms + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			div_cnt  <= '0;
			hi_ms    <= '0;
			lo_ms    <= '0;
			out_ms   <= '0;
			sec_ms   <= '0;
			long_out <= 1'b0;
		end
		else
		begin
			div_cnt  <= next_div_cnt;
			hi_ms    <= next_hi_ms;
			lo_ms    <= next_lo_ms;
			out_ms   <= next_out_ms;
			sec_ms   <= next_sec_ms;
			long_out <= next_long_out;
		end
	end

	// indication classes seen at the controller outputs
	always_comb
	begin
		steady      = hand_s && (hi_ms == MS_W'(STEADY_MS));
		dark        = !walk_s && !hand_s && (lo_ms == MS_W'(DARK_MS));
		flash       = pwr_s && !walk_s && !steady && !dark;
		flash_start = flash && !flash_prev;
		flash_end   = !flash && flash_prev;
		sec_tick    = ms_tick && (sec_ms == MS_W'(MS_PER_SECOND - 1));
	end

	// timing comes only from the observed drives
	always_comb
	begin
		next_state      = state;
		next_learned    = learned;
		next_remain     = remain;
		next_meas       = meas;
		next_short_prev = short_prev;
		case (state)
			ST_LEARN_WAIT:
			begin
				if (flash_start)
				begin
					next_meas  = COUNT_RST;
					next_state = ST_LEARN_MEAS;
				end
			end
			ST_LEARN_MEAS:
			begin
				if (sec_tick && meas != MAX_COUNT)
					next_meas = meas + 1'b1;
				if (flash_end)
				begin
					if (dark || meas == COUNT_RST)
						next_state = ST_LEARN_WAIT;
					else
					begin
						next_learned    = meas;
						next_short_prev = COUNT_RST;
						next_state      = ST_IDLE;
					end
				end
			end
			// count starts at flash, however long the walk
			ST_IDLE:
			begin
				if (flash_start)
				begin
					next_remain = learned;
					next_meas   = COUNT_RST;
					next_state  = ST_COUNT;
				end
			end
			ST_COUNT:
			begin
				if (sec_tick)
				begin
					if (meas != MAX_COUNT)
						next_meas = meas + 1'b1;
					if (remain != COUNT_RST)
						next_remain = remain - 1'b1;
					else
						next_state = ST_LEARN_WAIT;
				end
				if (flash_end)
				begin
					// early steady or dark head suspends timing
					next_state = ST_IDLE;
					if (!dark && meas < learned)
					begin
						// a single short cycle is a preemption
						if (meas == short_prev)
							next_state = ST_LEARN_WAIT;
						else
							next_short_prev = meas;
					end
					else
						next_short_prev = COUNT_RST;
				end
				// preemption during flash runs on untouched
			end
			default:
				next_state = ST_LEARN_WAIT;
		endcase
		// long outage forces a dark relearn cycle; a flash that starts
		// as supply returns is measured, so only one cycle stays dark
		if (long_out)
		begin
			next_meas  = COUNT_RST;
			next_state = flash_start ? ST_LEARN_MEAS : ST_LEARN_WAIT;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state      <= ST_LEARN_WAIT;
			learned    <= COUNT_RST;
			remain     <= COUNT_RST;
			meas       <= COUNT_RST;
			short_prev <= COUNT_RST;
			flash_prev <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			learned    <= next_learned;
			remain     <= next_remain;
			meas       <= next_meas;
			short_prev <= next_short_prev;
			flash_prev <= flash;
		end
	end

	// digits dark as soon as supply loss is seen, no dimming
	always_comb
	begin
		show     = pwr_s && (state == ST_COUNT);
		tens_val = 4'(remain / 7'd10);
		ones_val = 4'(remain % 7'd10);
	end

	// each segment bit feeds both emitter rows of the segment
	pcc_digit u_tens
	(
		.clk   (clk),
		.srst  (srst),
		.blank (!show || tens_val == 4'h0),
		.value (tens_val),
		.seg   (seg_tens)
	);

	pcc_digit u_ones
	(
		.clk   (clk),
		.srst  (srst),
		.blank (!show),
		.value (ones_val),
		.seg   (seg_ones)
	);
endmodule // pcc_countdown

// ### bench/pcc_countdown_monitor.sv
`timescale 1ns/1ps
module pcc_countdown_monitor
	import pcc_pkg::*;
#(
	parameter int MS_DIV = MS_CYCLES
)
(
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       walk_drive,
	input wire logic       hand_drive,
	input wire logic       supply_ok,
	input wire logic [6:0] seg_tens,
	input wire logic [6:0] seg_ones
);
	localparam int LIM = STEADY_MS * MS_DIV + 8;
	int   hi_cnt;
	int   next_hi_cnt;
	logic lit;
	assign lit = |{seg_tens, seg_ones};
	// saturates so a long steady hand cannot wrap
	always_comb
	begin
		next_hi_cnt = hand_drive ? hi_cnt + int'(hi_cnt < LIM) : 0;
	end
	always_ff @(posedge clk)
	begin
		hi_cnt <= srst ? 0 : next_hi_cnt;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	rst_dark_a: assert property (disable iff (1'b0) srst |=> !lit)
		else $error("digits lit after reset");
	tens_zero_a: assert property (seg_tens != 7'h3f)
		else $error("leading zero shown");
	ones_code_a: assert property (seg_ones inside {7'h00, 7'h3f, 7'h06, 7'h5b, 7'h4f,
		7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f}) else $error("bad segment code");
	walk_blank_a: assert property ($rose(walk_drive) |-> ##[1:6] !lit)
		else $error("walk did not blank");
	supply_blank_a: assert property ($fell(supply_ok) |-> ##[1:6] !lit)
		else $error("outage did not blank");
	supply_dark_a: assert property (!supply_ok [*8] |=> !lit)
		else $error("lit without supply");
	steady_dark_a: assert property (hi_cnt == LIM |-> !lit)
		else $error("lit under steady hand");
	zero_hold_a: assert property ($past(seg_ones) == 7'h3f && $past(seg_tens) == 7'h00
		&& seg_ones != 7'h3f |-> !lit) else $error("count left zero");
endmodule // pcc_countdown_monitor

bind pcc_countdown pcc_countdown_monitor #(.MS_DIV(MS_DIV)) mon_u (.clk(clk), .srst(srst),
	.walk_drive(walk_drive), .hand_drive(hand_drive), .supply_ok(supply_ok),
	.seg_tens(seg_tens), .seg_ones(seg_ones));

// ### bench/pcc_ctrl_model.sv
`timescale 1ns/1ps
module pcc_ctrl_model
(
	input  wire logic clk,
	output logic      walk_drive,
	output logic      hand_drive
);
	initial
	begin
		walk_drive = 1'b1;
		hand_drive = 1'b0;
	end
	// flash follows walk at once, however short
	task automatic cycle(input int f, input int s, input int w);
		walk_drive = 1'b0;
		for (int i = 0; i < f; i++)
		begin
			hand_drive = i % 800 < 400;
			@(negedge clk);
		end
		// steady hand ahead of the next walk
		if (s > 0) hand_drive = 1'b1;
		repeat (s) @(negedge clk);
		// next walk with no dark interval between
		hand_drive = 1'b0;
		walk_drive = 1'b1;
		repeat (w) @(negedge clk);
	endtask
	// walk and hand both dark from the moment walk ends
	task automatic dark_head(input int d, input int w);
		walk_drive = 1'b0;
		hand_drive = 1'b0;
		repeat (d) @(negedge clk);
		walk_drive = 1'b1;
		repeat (w) @(negedge clk);
	endtask
endmodule // pcc_ctrl_model

// ### bench/pedestrian_clearance_countdown_tb_top.sv
`timescale 1ns/1ps
module pedestrian_clearance_countdown_tb_top;
	import pcc_pkg::*;
	localparam int DIV = 1;
	localparam int SEC = MS_PER_SECOND * DIV;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic        supply_ok = 1'b1;
	logic        walk_drive;
	logic        hand_drive;
	logic [6:0]  seg_tens;
	logic [6:0]  seg_ones;
	logic [13:0] exp_q[$];
	logic [13:0] last = 14'h0;
	int          error_cnt = 0;
	int          n_tests = 0;
	int          seed = 32'h5a4e;
	always #2 clk = ~clk;
	pcc_countdown #(.MS_DIV(DIV)) dut_u (.clk(clk), .srst(srst), .walk_drive(walk_drive),
		.hand_drive(hand_drive), .supply_ok(supply_ok), .seg_tens(seg_tens),
		.seg_ones(seg_ones));
	pcc_ctrl_model ctrl_u (.clk(clk), .walk_drive(walk_drive), .hand_drive(hand_drive));
	function automatic logic [13:0] enc(input int v);
		logic [6:0] tab[10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
			7'h7f, 7'h6f};
		return {v > 9 ? tab[v / 10] : 7'h00, tab[v % 10]};
	endfunction
	task automatic check(input logic [13:0] seen);
		logic [13:0] want;
		want = exp_q.size() > 0 ? exp_q.pop_front() : 14'h3fff;
		n_tests++;
		if (want !== seen)
		begin
			error_cnt++;
			$display("mismatch segs expected %h seen %h", want, seen);
		end
	endtask
	// n is the count shown, 0 for a dark cycle; hand flashes f cycles, then steady s
	task automatic run(input int n, input int f, input int s);
		int eff;
		int v;
		eff = f + (s < STEADY_MS * DIV ? s : STEADY_MS * DIV);
		v = n;
		while (n > 0 && v >= 0 && v >= n - eff / SEC)
		begin
			exp_q.push_back(enc(v));
			v--;
		end
		if (n > 0)
			exp_q.push_back(14'h0);
		ctrl_u.cycle(f, s, 300 + ($random(seed) & 511));
		$display("test n=%0d f=%0d s=%0d done", n, f, s);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge clk)
		if ({seg_tens, seg_ones} !== last)
		begin
			last = {seg_tens, seg_ones};
			check(last);
		end
	initial
	begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		run(0, 3500, 0);
		run(3, 3500, 0);
		run(3, 2500, 0);
		run(3, 3500, 0);
		run(3, 500, 2000);
		supply_ok = 1'b0;
		repeat (2000) @(negedge clk);
		supply_ok = 1'b1;
		run(0, 3500, 0);
		run(3, 3500, 0);
		run(3, 5500, 0);
		run(0, 5500, 0);
		run(5, 5500, 0);
		// dark head blanks after 1.2 s shown, learned value kept
		exp_q.push_back(enc(5));
		exp_q.push_back(enc(4));
		exp_q.push_back(14'h0);
		ctrl_u.dark_head(2000, 400);
		$display("test dark head done");
		run(5, 2500, 0);
		run(5, 2500, 0);
		run(0, 2500, 0);
		run(2, 2500, 0);
		for (int i = 0; i < 100 && exp_q.size() > 0; i++)
			@(negedge clk);
		if (exp_q.size() > 0)
			check(14'h3fff);
		stop_test();
	end
endmodule // pedestrian_clearance_countdown_tb_top
